// File: fiov_pkg.sv
/*
 * Package for the FIFO interrupt overview block: register offsets, field
 * positions, reset values and AXI4-Lite response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package fiov_pkg;

   localparam int          ADDR_WIDTH           = 8;
   localparam int          NUM_FIFOS            = 16;
   localparam int          NUM_BLOCKS           = 4;
   localparam int          FIFOS_PER_BLOCK      = 4;

   localparam logic [7:0]  OFFS_OVERVIEW        = 8'h10;
   localparam logic [7:0]  OFFS_BLOCK0_STATUS   = 8'h20;
   localparam logic [7:0]  OFFS_BLOCK1_STATUS   = 8'h24;
   localparam logic [7:0]  OFFS_BLOCK2_STATUS   = 8'h28;
   localparam logic [7:0]  OFFS_BLOCK3_STATUS   = 8'h2C;
   localparam logic [7:0]  OFFS_MASK            = 8'h30;

   localparam int          POS_BLOCK0_PENDING   = 0;
   localparam int          POS_BLOCK1_PENDING   = 1;
   localparam int          POS_BLOCK2_PENDING   = 2;
   localparam int          POS_BLOCK3_PENDING   = 3;

   localparam logic [3:0]  RESET_OVERVIEW       = 4'h0;
   localparam logic [3:0]  RESET_MASK           = 4'h0;

   localparam logic [1:0]  RESP_OKAY            = 2'h0;
   localparam logic [1:0]  RESP_SLVERR          = 2'h2;

   typedef enum logic [1:0] {
      FIOV_ST_IDLE = 2'b01,
      FIOV_ST_RESP = 2'b10
   } fiov_state_type;

endpackage

// File: fiov_block_or.sv
/*
 * Reduces the pending flags of one FIFO block (transmit and receive FIFOs)
 * into a single block summary bit.
 * Assumes pending flags are levels on core_clk held by the FIFO logic.
 */
module fiov_block_or (
   input  wire logic [3:0] tx_pending,
   input  wire logic [3:0] rx_pending,
   output logic            block_pending
);

   assign block_pending = |{tx_pending, rx_pending};

endmodule

// File: fiov_top.sv
/*
 * FIFO interrupt overview register with AXI4-Lite slave, per-block FIFO
 * status registers, block mask register and masked interrupt output.
 * Register words: overview at 0x10, bits 3:0, one summary bit per FIFO
 * block; block status at 0x20, 0x24, 0x28 and 0x2C, bits 3:0 for the
 * transmit FIFOs and bits 7:4 for the receive FIFOs of that block; mask
 * at 0x30, bits 3:0, the only writable word. Upper bits read as zero.
 * Unmapped offsets and writes to read-only words answer SLVERR.
 * Assumes per-FIFO pending flags come from logic on core_clk and are
 * cleared by that logic, never by reads of this block.
 * Assumes srst is synchronous to core_clk, and that the bus master holds
 * each valid and its payload until the matching ready.
 * Assumes wstrb bit 0 qualifies the mask byte; without it a mask write
 * answers OKAY and leaves the mask alone.
 */
// Local design decision: the AXI4-Lite interface to the registers.
// Notes on behaviour
// - An overview bit reads one while any condition of its block is pending.
// - A pending block drives the interrupt output only when its mask bit is one.
// - Reading the overview register clears nothing anywhere.
// - Bit 0 is the OR of transmit and receive FIFOs 0 to 3.
// - Bit 1 is the OR of transmit and receive FIFOs 4 to 7.
// - Bit 2 is the OR of transmit and receive FIFOs 8 to 11.
// - Bit 3 is the OR of transmit and receive FIFOs 12 to 15.
// - Each block has its own status register naming which FIFO is pending.
// - All four overview bits read zero while srst is high.
module fiov_top (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [15:0] tx_fifo_pending,
   input  wire logic [15:0] rx_fifo_pending,
   output logic             irq_out,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   logic [3:0]                  block_raw;
   logic [3:0]                  overview;
   logic [3:0]                  mask_reg;
   logic                        irq_reg;
   logic                        aw_held_reg;
   logic                        w_held_reg;
   logic [7:0]                  awaddr_reg;
   logic [31:0]                 wdata_reg;
   logic [3:0]                  wstrb_reg;
   logic [1:0]                  bresp_reg;
   logic                        bvalid_reg;
   logic [31:0]                 rdata_reg;
   logic [1:0]                  rresp_reg;
   fiov_pkg::fiov_state_type    rd_state_reg;
   logic                        wr_fire;
   logic                        rd_fire;
   logic [31:0]                 rd_word;
   logic                        rd_hit;
   logic [3:0]                  irq_masked;
   logic                        wr_to_mask;

   function automatic logic [7:0] fiov_block_status(input logic [15:0] tx,
                                                    input logic [15:0] rx,
                                                    input int          blk);
      logic [7:0] v;
      v = {rx[blk*4 +: 4], tx[blk*4 +: 4]};
      return v;
   endfunction

   // Decoders shared by the write path and both answer channels.
   function automatic logic fiov_is_mask(input logic [7:0] addr);
      return addr == fiov_pkg::OFFS_MASK;
   endfunction

   function automatic logic [1:0] fiov_resp(input logic hit);
      return hit ? fiov_pkg::RESP_OKAY : fiov_pkg::RESP_SLVERR;
   endfunction

   genvar g;
   generate
      for (g = 0; g < fiov_pkg::NUM_BLOCKS; g++) begin : gen_blk
         fiov_block_or u_or (
            .tx_pending    (tx_fifo_pending[g*4 +: 4]),
            .rx_pending    (rx_fifo_pending[g*4 +: 4]),
            .block_pending (block_raw[g])
         );
      end
   endgenerate

   // Overview bits are pure combinational ORs, forced to zero in reset.
   always_comb begin
      overview                                  = fiov_pkg::RESET_OVERVIEW;
      if (!srst) begin
         overview[fiov_pkg::POS_BLOCK0_PENDING] = block_raw[0];
         overview[fiov_pkg::POS_BLOCK1_PENDING] = block_raw[1];
         overview[fiov_pkg::POS_BLOCK2_PENDING] = block_raw[2];
         overview[fiov_pkg::POS_BLOCK3_PENDING] = block_raw[3];
      end
   end

   // Masked interrupt output, registered.
   assign irq_masked = overview & mask_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |irq_masked;
      end
   end
   assign irq_out = irq_reg;

   // Write channel capture: address and data accepted in either order.
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_to_mask    = wr_fire && fiov_is_mask(awaddr_reg);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         w_held_reg <= 1'b0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata;
         wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end
   end

   // Mask register is the only writable register.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask_reg <= fiov_pkg::RESET_MASK;
      end else if (wr_to_mask && wstrb_reg[0]) begin
         mask_reg <= wdata_reg[3:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= fiov_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= fiov_resp(fiov_is_mask(awaddr_reg));
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // Read decode; reads only sample state and clear nothing.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         fiov_pkg::OFFS_OVERVIEW:      rd_word[3:0] = overview;
         fiov_pkg::OFFS_BLOCK0_STATUS: rd_word[7:0] = fiov_block_status(tx_fifo_pending, rx_fifo_pending, 0);
         fiov_pkg::OFFS_BLOCK1_STATUS: rd_word[7:0] = fiov_block_status(tx_fifo_pending, rx_fifo_pending, 1);
         fiov_pkg::OFFS_BLOCK2_STATUS: rd_word[7:0] = fiov_block_status(tx_fifo_pending, rx_fifo_pending, 2);
         fiov_pkg::OFFS_BLOCK3_STATUS: rd_word[7:0] = fiov_block_status(tx_fifo_pending, rx_fifo_pending, 3);
         fiov_pkg::OFFS_MASK:          rd_word[3:0] = mask_reg;
         default:                      rd_hit       = 1'b0;
      endcase
   end

   assign s_axi_arready = (rd_state_reg == fiov_pkg::FIOV_ST_IDLE);
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_state_reg <= fiov_pkg::FIOV_ST_IDLE;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= fiov_pkg::RESP_OKAY;
      end else begin
         case (rd_state_reg)
            fiov_pkg::FIOV_ST_IDLE: begin
               if (rd_fire) begin
                  rd_state_reg <= fiov_pkg::FIOV_ST_RESP;
                  rdata_reg    <= rd_word;
                  rresp_reg    <= fiov_resp(rd_hit);
               end
            end
            fiov_pkg::FIOV_ST_RESP: begin
               if (s_axi_rready) begin
                  rd_state_reg <= fiov_pkg::FIOV_ST_IDLE;
               end
            end
            default: begin
               rd_state_reg <= fiov_pkg::FIOV_ST_IDLE;
            end
         endcase
      end
   end
   assign s_axi_rvalid = (rd_state_reg == fiov_pkg::FIOV_ST_RESP);
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

endmodule

// File: fiov_chk.sv
/* Checker for fiov_top: register bus answers, overview read values, interrupt.
   Assumes the fiov_top ports only, one clock core_clk, srst synchronous. */
module fiov_chk (
   input wire logic        core_clk,
   input wire logic        srst,
   input wire logic [15:0] tx_fifo_pending,
   input wire logic [15:0] rx_fifo_pending,
   input wire logic        irq_out,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic [3:0] ov_now;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         ov_now[b] = |{tx_fifo_pending[4*b+:4], rx_fifo_pending[4*b+:4]};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_ov_read: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == fiov_pkg::OFFS_OVERVIEW |=>
      s_axi_rdata == {28'h000_0000, $past(ov_now)}) else $error("Overview read wrong.");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read not answered.");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read answer dropped.");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("Address taken during answer.");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("Write not answered.");
   a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write answer dropped.");
   a_irq_cause: assert property (irq_out |-> $past(|ov_now))
      else $error("Interrupt without pending block.");
   a_rst_quiet: assert property (disable iff (1'b0) srst |=>
      !s_axi_rvalid && !s_axi_bvalid && !irq_out) else $error("Reset not quiet.");
endmodule
bind fiov_top fiov_chk u_chk (.core_clk, .srst, .tx_fifo_pending, .rx_fifo_pending, .irq_out,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

// File: fiov_top_tb_top.sv
/* Self-checking bench for fiov_top with random pending flags and mask.
   Assumes the bench drives every port itself; no other model. */
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module fiov_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, srst = 1, irq_out, awv = 0, awr, wv = 0, wr_r, bv, bry = 0;
   logic arv = 0, arr, rv, rry = 0;
   logic [15:0] tx = 0, rx = 0, nt, nr;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_d, lf = 32'h0001_4E7C;
   logic [3:0] ws = 0, m = 0;
   logic [1:0] br, rr;
   int failures = 0, n_compared = 0;
   logic lag = 0;
   fiov_top uut (.core_clk, .srst, .tx_fifo_pending(tx), .rx_fifo_pending(rx), .irq_out,
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry));
   always #2 core_clk = ~core_clk;
   function automatic logic [31:0] nxt(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [3:0] ov_f(logic [15:0] t, logic [15:0] r);
      for (int b = 0; b < 4; b++) ov_f[b] = |{t[4*b+:4], r[4*b+:4]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic ta, tw, tv, tb, go;
      go = 1'b1;
      @(posedge core_clk);
      awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= !lag;
      while (go) begin
         #1 ta = awv && awr; tw = wv && wr_r; tv = bv; tb = bv && bry;
         @(posedge core_clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         if (tb) begin
            go = 1'b0;
            bry <= 0;
            `CHK(br, er)
         end else if (tv) begin
            bry <= 1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tv, tr, go;
      go = 1'b1;
      @(posedge core_clk);
      ara <= a; arv <= 1; rry <= !lag;
      while (go) begin
         #1 ta = arv && arr; tv = rv; tr = rv && rry;
         @(posedge core_clk);
         if (ta) arv <= 0;
         if (tr) begin
            go = 1'b0;
            rry <= 0;
            `CHK(rd_d, ed)
            `CHK(rr, er)
         end else if (tv) begin
            rry <= 1;
         end
      end
   endtask
   task automatic chk_irq();
      repeat (2) @(posedge core_clk);
      #1 `CHK(irq_out, |(ov_f(tx, rx) & m))
   endtask
   task automatic complete_run();
      $display("Compared %0d, failures %0d.", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      srst <= 0;
      rd(fiov_pkg::OFFS_OVERVIEW, 32'h0000_0000, fiov_pkg::RESP_OKAY);
      rd(fiov_pkg::OFFS_MASK, 32'h0000_0000, fiov_pkg::RESP_OKAY);
      rd(8'h3C, 32'h0000_0000, fiov_pkg::RESP_SLVERR);
      wr(fiov_pkg::OFFS_OVERVIEW, 32'hFFFF_FFFF, 4'hF, fiov_pkg::RESP_SLVERR);
      for (int i = 0; i < 32; i++) begin
         tx <= (i < 16) ? 16'h0001 << i : 16'h0000;
         rx <= (i >= 16) ? 16'h0001 << (i - 16) : 16'h0000;
         rd(fiov_pkg::OFFS_OVERVIEW, 32'h0000_0001 << ((i % 16) / 4), 2'h0);
      end
      for (int k = 0; k < 24; k++) begin
         lf = nxt(lf); nt = lf[15:0] & lf[31:16]; lf = nxt(lf); nr = lf[15:0] & lf[31:16];
         tx <= nt; rx <= nr;
         lag = lf[7];
         wr(fiov_pkg::OFFS_MASK, {28'h000_0000, lf[3:0]}, lf[4] ? 4'hF : 4'hE, 2'h0);
         if (lf[4]) m = lf[3:0];
         chk_irq();
         rd(fiov_pkg::OFFS_MASK, {28'h000_0000, m}, 2'h0);
         rd(fiov_pkg::OFFS_OVERVIEW, {28'h000_0000, ov_f(nt, nr)}, 2'h0);
         rd(fiov_pkg::OFFS_OVERVIEW, {28'h000_0000, ov_f(nt, nr)}, 2'h0);
         rd(fiov_pkg::OFFS_BLOCK0_STATUS + {lf[6:5], 2'b00},
            {24'h00_0000, nr[4*lf[6:5]+:4], nt[4*lf[6:5]+:4]}, 2'h0);
      end
      tx <= 16'h0000; rx <= 16'h0000;
      rd(fiov_pkg::OFFS_OVERVIEW, 32'h0000_0000, 2'h0);
      chk_irq();
      @(posedge core_clk);
      tx <= 16'hFFFF;
      wr(fiov_pkg::OFFS_MASK, 32'h0000_000F, 4'hF, fiov_pkg::RESP_OKAY);
      m = 4'hF;
      chk_irq();
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 `CHK(irq_out, 1'b0)
      @(posedge core_clk);
      srst <= 1'b0;
      m = 4'h0;
      rd(fiov_pkg::OFFS_MASK, 32'h0000_0000, fiov_pkg::RESP_OKAY);
      rd(fiov_pkg::OFFS_OVERVIEW, 32'h0000_000F, fiov_pkg::RESP_OKAY);
      chk_irq();
      complete_run();
   end
endmodule
